/* shared/irqtb_pkg.sv */
// Constants shared by the interrupt controller and its time base chain
`default_nettype none
package irqtb_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [5:0] REG_PRIMARY_IDX = 6'h0B;
  localparam logic [5:0] REG_TIMER_IDX = 6'h1E;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Field positions in the primary control register
  localparam int GLOBAL_EN_BIT = 0;
  localparam int EXT_EN_BIT = 1;
  localparam int TICK_EN_BIT = 2;
  localparam int RTC_EN_BIT = 3;
  localparam int EXT_PEND_BIT = 4;
  localparam int TICK_PEND_BIT = 5;
  localparam int RTC_PEND_BIT = 6;
  // Field positions in the timer control register
  localparam int CNT_EN_BIT = 0;
  localparam int CNT_PEND_BIT = 4;
  // Values after reset: every source disabled, nothing pending
  localparam logic [3:0] ENABLE_RST = 4'h0;
  localparam logic [3:0] PENDING_RST = 4'h0;
  localparam logic GLOBAL_EN_RST = 1'b0;
  // Source index doubles as priority rank, zero highest
  localparam int NUM_SRC = 4;
  localparam int SRC_EXT = 0;
  localparam int SRC_TICK = 1;
  localparam int SRC_RTC = 2;
  localparam int SRC_CNT = 3;
  localparam logic [7:0] VEC_EXT = 8'h04;
  localparam logic [7:0] VEC_TICK = 8'h08;
  localparam logic [7:0] VEC_RTC = 8'h0C;
  localparam logic [7:0] VEC_CNT = 8'h10;
  localparam logic [7:0] VEC_RST = 8'h00;
  // Divider chain: 7-stage divider then 8-bit prescaler
  localparam int DIV_STAGES = 7;
  localparam int PRESC_BITS = 8;
  localparam int CHAIN_W = DIV_STAGES + PRESC_BITS;
  localparam logic [CHAIN_W-1:0] CHAIN_RST = 15'h0000;
  localparam int TICK_EXP_MIN = 12;
  localparam int OUT_EXP_MIN = 2;
  // Instruction clock is the system clock divided by four
  localparam int SYS_DIV = 4;
  localparam logic [1:0] SYS_DIV_LAST = 2'(SYS_DIV - 1);
  localparam logic [1:0] SYS_DIV_RST = 2'h0;
  typedef enum logic [1:0] {
    CS_SYS = 2'b00,
    CS_WDT = 2'b01,
    CS_RTC = 2'b10
  } irqtb_clksel_e;
endpackage
`default_nettype wire

/* src/irqtb_ctrl.sv */
// Interrupt controller with time base, APB register access
// Overview of operation
// - Primary register 0BH: global, external, tick, rtc enables in bits 0-3.
// - Primary bits 4-6 are external, tick, rtc pending; bit 7 reads 0.
// - Timer register 1EH: counter enable bit 0, pending bit 4, rest 0.
// - Falling edge on external interrupt pin sets external pending.
// - Enabled external request calls 04H, clears its flag and global enable.
// - Timer A or B overflow sets counter pending; service calls 10H.
// - Time base period sets tick pending; service calls 08H.
// - Real time clock period sets rtc pending; service calls 0CH.
// - No further acknowledge until return or software re-enables.
// - Return-from-interrupt sets global enable; plain return does not.
// - Requests seen between phase two pulses are served at the later.
// - Fixed priority external, tick, rtc, counter; global enable masks all.
// - Pending flags stay until serviced or cleared by software.
// - Chain of 7-stage divider and 8-bit prescaler, three clock sources.
// - LCD clock fs/4 to fs/512, buzzer clock fs/4 to fs/512.
// - Time base period fs/4096 to fs/32768 sets tick pending.
// - In halt the tick keeps counting from oscillator sources and wakes.
// - Tick already pending at halt entry cannot wake the device.
// - Stack full blocks every acknowledge until the pointer drops.
// - Acknowledge pushes only the program counter, never status.
// - Every interrupt source can wake the device from halt.
`default_nettype none
module irqtb_ctrl (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXT_IRQ_N,
  input wire logic TIMER_A_OVF,
  input wire logic TIMER_B_OVF,
  input wire logic RTC_PERIOD,
  input wire logic PHASE_TWO_PULSE,
  input wire logic STACK_FULL,
  input wire logic RETURN_FROM_IRQ,
  input wire logic HALTED,
  input wire logic WATCHDOG_RC_OSC,
  input wire logic RTC_CRYSTAL_OSC,
  input wire logic [1:0] FS_CLK_SEL,
  input wire logic [1:0] TICK_PERIOD_SEL,
  input wire logic [2:0] LCD_CLK_SEL,
  input wire logic [2:0] BUZZER_CLK_SEL,
  output logic IRQ_CALL,
  output logic [7:0] IRQ_VECTOR,
  output logic WAKE_UP,
  output logic LCD_CLK,
  output logic BUZZER_CLK
);
  localparam int NS = irqtb_pkg::NUM_SRC;

  logic ext_s1_r, ext_s2_r, ext_s3_r;
  logic wdt_s1_r, wdt_s2_r, wdt_s3_r;
  logic rtc_s1_r, rtc_s2_r, rtc_s3_r;
  logic ext_fall;
  logic wdt_rise, rtc_rise;
  logic [1:0] sysdiv_r;
  logic sys_tick;
  logic fs_tick;
  logic tick_timeout;
  logic [NS-1:0] en_r;
  logic [NS-1:0] pend_r;
  logic global_en_r;
  logic [NS-1:0] set_ev;
  logic [NS-1:0] gated_req;
  logic [NS-1:0] grant;
  logic [7:0] grant_vec;
  logic ack;
  logic halted_r;
  logic [NS-1:0] wake_arm_r;
  logic setup_ph, wr_access;
  logic hit_primary, hit_timer;
  logic [7:0] primary_view, timer_view;

  // Word index decode, used by the read and the write path
  function automatic logic is_reg(input logic [7:0] addr,
                                  input logic [5:0] idx);
    return (addr[1:0] == 2'h0) && (addr[7:2] == idx);
  endfunction

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);

  // Pin and foreign oscillator inputs each cross through three flops
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      ext_s1_r <= 1'b1;
      ext_s2_r <= 1'b1;
      ext_s3_r <= 1'b1;
    end
    else
    begin
      ext_s1_r <= EXT_IRQ_N;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      wdt_s1_r <= 1'b0;
      wdt_s2_r <= 1'b0;
      wdt_s3_r <= 1'b0;
      rtc_s1_r <= 1'b0;
      rtc_s2_r <= 1'b0;
      rtc_s3_r <= 1'b0;
    end
    else
    begin
      wdt_s1_r <= WATCHDOG_RC_OSC;
      wdt_s2_r <= wdt_s1_r;
      wdt_s3_r <= wdt_s2_r;
      rtc_s1_r <= RTC_CRYSTAL_OSC;
      rtc_s2_r <= rtc_s1_r;
      rtc_s3_r <= rtc_s2_r;
    end
  end

  assign ext_fall = ext_s3_r && !ext_s2_r;
  assign wdt_rise = wdt_s2_r && !wdt_s3_r;
  assign rtc_rise = rtc_s2_r && !rtc_s3_r;

  // Instruction clock stops with the system oscillator in halt
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      sysdiv_r <= irqtb_pkg::SYS_DIV_RST;
    else if (!HALTED)
      sysdiv_r <= (sysdiv_r == irqtb_pkg::SYS_DIV_LAST) ?
                  irqtb_pkg::SYS_DIV_RST : sysdiv_r + 2'h1;
  end

  assign sys_tick = !HALTED && (sysdiv_r == irqtb_pkg::SYS_DIV_LAST);

  // Oscillator sources keep the chain alive through halt
  always_comb
  begin
    case (irqtb_pkg::irqtb_clksel_e'(FS_CLK_SEL))
      irqtb_pkg::CS_SYS: fs_tick = sys_tick;
      irqtb_pkg::CS_WDT: fs_tick = wdt_rise;
      irqtb_pkg::CS_RTC: fs_tick = rtc_rise;
      default: fs_tick = sys_tick;
    endcase
  end

  irqtb_divchain u_chain (
    .clk(CLK_SYS),
    .rst(RESET),
    .fs_tick(fs_tick),
    .tick_sel(TICK_PERIOD_SEL),
    .lcd_sel(LCD_CLK_SEL),
    .buz_sel(BUZZER_CLK_SEL),
    .tick_timeout(tick_timeout),
    .lcd_clk(LCD_CLK),
    .buz_clk(BUZZER_CLK)
  );

  // Hardware events that raise the pending flags
  always_comb
  begin
    set_ev = '0;
    set_ev[irqtb_pkg::SRC_EXT] = ext_fall;
    set_ev[irqtb_pkg::SRC_TICK] = tick_timeout;
    set_ev[irqtb_pkg::SRC_RTC] = RTC_PERIOD;
    set_ev[irqtb_pkg::SRC_CNT] = TIMER_A_OVF || TIMER_B_OVF;
  end

  // APB: zero wait states, read data latched in the setup cycle
  assign setup_ph = PSEL && !PENABLE;
  assign wr_access = PSEL && PENABLE && PWRITE;
  assign hit_primary = is_reg(PADDR, irqtb_pkg::REG_PRIMARY_IDX);
  assign hit_timer = is_reg(PADDR, irqtb_pkg::REG_TIMER_IDX);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit_primary && !hit_timer;

  always_comb
  begin
    primary_view = 8'h00;
    primary_view[irqtb_pkg::GLOBAL_EN_BIT] = global_en_r;
    primary_view[irqtb_pkg::EXT_EN_BIT] = en_r[irqtb_pkg::SRC_EXT];
    primary_view[irqtb_pkg::TICK_EN_BIT] = en_r[irqtb_pkg::SRC_TICK];
    primary_view[irqtb_pkg::RTC_EN_BIT] = en_r[irqtb_pkg::SRC_RTC];
    primary_view[irqtb_pkg::EXT_PEND_BIT] = pend_r[irqtb_pkg::SRC_EXT];
    primary_view[irqtb_pkg::TICK_PEND_BIT] = pend_r[irqtb_pkg::SRC_TICK];
    primary_view[irqtb_pkg::RTC_PEND_BIT] = pend_r[irqtb_pkg::SRC_RTC];
    timer_view = 8'h00;
    timer_view[irqtb_pkg::CNT_EN_BIT] = en_r[irqtb_pkg::SRC_CNT];
    timer_view[irqtb_pkg::CNT_PEND_BIT] = pend_r[irqtb_pkg::SRC_CNT];
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      PRDATA <= 32'h0000_0000;
    else if (setup_ph && !PWRITE)
    begin
      if (hit_primary)
        PRDATA <= {24'h00_0000, primary_view};
      else if (hit_timer)
        PRDATA <= {24'h00_0000, timer_view};
      else
        PRDATA <= 32'h0000_0000;
    end
  end

  // Acknowledge only on a phase two pulse, with global enable set
  assign gated_req = pend_r & en_r & {NS{global_en_r}};

  irqtb_prio u_prio (
    .req(gated_req),
    .grant(grant),
    .vector(grant_vec)
  );

  // Halt and a full stack both defer service; the flag keeps waiting
  assign ack = PHASE_TWO_PULSE && (|gated_req) && !STACK_FULL
               && !HALTED;

  // One pulse per call; the core pushes the program counter only
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      IRQ_CALL <= 1'b0;
      IRQ_VECTOR <= irqtb_pkg::VEC_RST;
    end
    else
    begin
      IRQ_CALL <= ack;
      if (ack)
        IRQ_VECTOR <= grant_vec;
    end
  end

  // Later assignments win: write, then service clear, then hardware set
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      pend_r <= irqtb_pkg::PENDING_RST;
    else
    begin
      if (wr_access && hit_primary)
      begin
        pend_r[irqtb_pkg::SRC_EXT] <= PWDATA[irqtb_pkg::EXT_PEND_BIT];
        pend_r[irqtb_pkg::SRC_TICK] <= PWDATA[irqtb_pkg::TICK_PEND_BIT];
        pend_r[irqtb_pkg::SRC_RTC] <= PWDATA[irqtb_pkg::RTC_PEND_BIT];
      end
      if (wr_access && hit_timer)
        pend_r[irqtb_pkg::SRC_CNT] <= PWDATA[irqtb_pkg::CNT_PEND_BIT];
      for (int i = 0; i < NS; i++)
      begin
        if (ack && grant[i])
          pend_r[i] <= 1'b0;
        if (set_ev[i])
          pend_r[i] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      en_r <= irqtb_pkg::ENABLE_RST;
    else
    begin
      if (wr_access && hit_primary)
      begin
        en_r[irqtb_pkg::SRC_EXT] <= PWDATA[irqtb_pkg::EXT_EN_BIT];
        en_r[irqtb_pkg::SRC_TICK] <= PWDATA[irqtb_pkg::TICK_EN_BIT];
        en_r[irqtb_pkg::SRC_RTC] <= PWDATA[irqtb_pkg::RTC_EN_BIT];
      end
      if (wr_access && hit_timer)
        en_r[irqtb_pkg::SRC_CNT] <= PWDATA[irqtb_pkg::CNT_EN_BIT];
    end
  end

  // Software may re-enable inside a routine to allow nesting
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      global_en_r <= irqtb_pkg::GLOBAL_EN_RST;
    else if (ack)
      global_en_r <= 1'b0;
    else if (RETURN_FROM_IRQ)
      global_en_r <= 1'b1;
    else if (wr_access && hit_primary)
      global_en_r <= PWDATA[irqtb_pkg::GLOBAL_EN_BIT];
  end

  // Flags already pending at halt entry lose their wake-up power
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      halted_r <= 1'b0;
      wake_arm_r <= '0;
    end
    else
    begin
      halted_r <= HALTED;
      if (HALTED && !halted_r)
        wake_arm_r <= ~pend_r;
      else if (!HALTED)
        wake_arm_r <= '0;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      WAKE_UP <= 1'b0;
    else
      WAKE_UP <= halted_r && HALTED && |(set_ev & wake_arm_r);
  end

  sequence s_ack;
    PHASE_TWO_PULSE && !STACK_FULL && !HALTED && (|gated_req);
  endsequence

  sequence s_call_out;
    IRQ_CALL && !global_en_r;
  endsequence

  ext_edge_a: assert property (
    (ext_s3_r && !ext_s2_r) |=> pend_r[irqtb_pkg::SRC_EXT])
    else $error("falling edge did not set external pending");

  call_timing_a: assert property (
    s_ack |=> s_call_out)
    else $error("acknowledge did not call and drop global enable");

  call_cause_a: assert property (
    IRQ_CALL |-> $past(PHASE_TWO_PULSE) && !$past(STACK_FULL))
    else $error("call without phase pulse or with full stack");

  vector_prio_a: assert property (
    s_ack ##0 pend_r[irqtb_pkg::SRC_EXT] && en_r[irqtb_pkg::SRC_EXT]
    |=> IRQ_VECTOR == irqtb_pkg::VEC_EXT)
    else $error("external request lost priority");

  tick_vector_a: assert property (
    s_ack ##0 grant == 4'h2 |=> IRQ_VECTOR == irqtb_pkg::VEC_TICK
    && !pend_r[irqtb_pkg::SRC_TICK] || $past(tick_timeout))
    else $error("time base service wrong");

  return_from_irq_set_a: assert property (
    RETURN_FROM_IRQ && !ack |=> global_en_r)
    else $error("return did not restore global enable");

  hold_off_a: assert property (
    IRQ_CALL |-> !ack)
    else $error("second acknowledge while global enable clear");

  flag_hold_a: assert property (
    pend_r[irqtb_pkg::SRC_CNT] && !ack && !(wr_access && hit_timer)
    |=> pend_r[irqtb_pkg::SRC_CNT])
    else $error("counter pending dropped without cause");

  read_zero_a: assert property (
    PRDATA[31:7] == 25'h0)
    else $error("unused read bits not zero");

  timer_ovf_a: assert property (
    TIMER_B_OVF |=> pend_r[irqtb_pkg::SRC_CNT])
    else $error("timer overflow did not set counter pending");

  halt_tick_a: assert property (
    HALTED && halted_r && !wake_arm_r[irqtb_pkg::SRC_TICK]
    && set_ev == 4'h2 |=> !WAKE_UP)
    else $error("stale time base flag woke the device");
endmodule
`default_nettype wire

/* src/irqtb_divchain.sv */
// Multi-function divider chain: time base, LCD and buzzer clocks
`default_nettype none
module irqtb_divchain (
  input wire logic clk,
  input wire logic rst,
  input wire logic fs_tick,
  input wire logic [1:0] tick_sel,
  input wire logic [2:0] lcd_sel,
  input wire logic [2:0] buz_sel,
  output logic tick_timeout,
  output logic lcd_clk,
  output logic buz_clk
);
  localparam int W = irqtb_pkg::CHAIN_W;
  logic [W-1:0] chain_r;
  logic [W-1:0] wrap_mask;
  int tick_exp;

  // 7-stage divider and 8-bit prescaler as one synchronous count
  always_ff @(posedge clk)
  begin
    if (rst)
      chain_r <= irqtb_pkg::CHAIN_RST;
    else if (fs_tick)
      chain_r <= chain_r + 1'b1;
  end

  // Period fs/2^n ends when the low n bits wrap
  always_comb
  begin
    tick_exp = irqtb_pkg::TICK_EXP_MIN + int'(tick_sel);
    wrap_mask = W'((32'h1 << tick_exp) - 32'h1);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tick_timeout <= 1'b0;
      lcd_clk <= 1'b0;
      buz_clk <= 1'b0;
    end
    else
    begin
      tick_timeout <= fs_tick && ((chain_r & wrap_mask) == wrap_mask);
      // Bit k toggles with period fs/2^(k+1)
      lcd_clk <= chain_r[irqtb_pkg::OUT_EXP_MIN - 1 + int'(lcd_sel)];
      buz_clk <= chain_r[irqtb_pkg::OUT_EXP_MIN - 1 + int'(buz_sel)];
    end
  end
endmodule
`default_nettype wire

/* src/irqtb_prio.sv */
// Fixed-priority picker of the enabled pending source and its vector
`default_nettype none
module irqtb_prio (
  input wire logic [3:0] req,
  output logic [3:0] grant,
  output logic [7:0] vector
);
  function automatic logic [7:0] vec_of(input logic [3:0] g);
    logic [7:0] v;
    v = irqtb_pkg::VEC_RST;
    if (g[irqtb_pkg::SRC_EXT])
      v = irqtb_pkg::VEC_EXT;
    else if (g[irqtb_pkg::SRC_TICK])
      v = irqtb_pkg::VEC_TICK;
    else if (g[irqtb_pkg::SRC_RTC])
      v = irqtb_pkg::VEC_RTC;
    else if (g[irqtb_pkg::SRC_CNT])
      v = irqtb_pkg::VEC_CNT;
    return v;
  endfunction

  // Lowest index wins
  always_comb
  begin
    grant = 4'h0;
    if (req[irqtb_pkg::SRC_EXT])
      grant[irqtb_pkg::SRC_EXT] = 1'b1;
    else if (req[irqtb_pkg::SRC_TICK])
      grant[irqtb_pkg::SRC_TICK] = 1'b1;
    else if (req[irqtb_pkg::SRC_RTC])
      grant[irqtb_pkg::SRC_RTC] = 1'b1;
    else if (req[irqtb_pkg::SRC_CNT])
      grant[irqtb_pkg::SRC_CNT] = 1'b1;
    vector = vec_of(grant);
  end
endmodule
`default_nettype wire

/* tb/irqtb_core_model.sv */
// Core sequencer and return stack model facing the interrupt controller
`default_nettype none
module irqtb_core_model #(
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic irq_call,
  input wire logic return_from_irq_req,
  input wire logic hold_full,
  output logic phase_pulse,
  output logic stack_full,
  output logic return_from_irq_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_cnt_r;
  int depth_r;
  always_ff @(posedge clk)
  begin
    if (rst)
      ph_cnt_r <= 2'h0;
    else
      ph_cnt_r <= ph_cnt_r + 2'h1;
  end
  assign phase_pulse = (ph_cnt_r == 2'h3);
  // Only the return address goes on the stack; status is software's job
  always_ff @(posedge clk)
  begin
    if (rst)
      depth_r <= 0;
    else if (irq_call && depth_r < DEPTH)
      depth_r <= depth_r + 1;
    else if (return_from_irq_pulse && depth_r > 0)
      depth_r <= depth_r - 1;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      return_from_irq_pulse <= 1'b0;
    else
      return_from_irq_pulse <= return_from_irq_req;
  end
  // Service routines never call further, so only interrupt calls eat a level
  assign stack_full = hold_full || depth_r >= DEPTH;
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the interrupt controller with time base
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, penable, pwrite, ext_n, halted, osc_w, osc_r;
  logic irq_call, wake, lcd, buz, ph, sfull, return_from_irq, return_from_irq_req, hold_full;
  logic pready, pslverr, perr;
  logic [1:0] fs_sel;
  logic [2:0] ev, buz_sel;
  logic [7:0] paddr, vec;
  logic [31:0] pwdata, prdata, rd;
  int miscompares, total_checks, cyc;
  localparam logic [7:0] PRI = {irqtb_pkg::REG_PRIMARY_IDX, 2'b00};
  localparam logic [7:0] TMR = {irqtb_pkg::REG_TIMER_IDX, 2'b00};
  localparam int TICK = irqtb_pkg::SYS_DIV << irqtb_pkg::TICK_EXP_MIN;
  localparam int OUTP = irqtb_pkg::SYS_DIV << irqtb_pkg::OUT_EXP_MIN;
  irqtb_ctrl dut (.CLK_SYS(clk), .RESET(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_IRQ_N(ext_n), .TIMER_A_OVF(ev[0]), .TIMER_B_OVF(ev[1]),
    .RTC_PERIOD(ev[2]), .PHASE_TWO_PULSE(ph), .STACK_FULL(sfull),
    .RETURN_FROM_IRQ(return_from_irq), .HALTED(halted), .WATCHDOG_RC_OSC(osc_w),
    .RTC_CRYSTAL_OSC(osc_r), .FS_CLK_SEL(fs_sel), .TICK_PERIOD_SEL(2'h0),
    .LCD_CLK_SEL(3'h0), .BUZZER_CLK_SEL(buz_sel), .IRQ_CALL(irq_call),
    .IRQ_VECTOR(vec), .WAKE_UP(wake), .LCD_CLK(lcd), .BUZZER_CLK(buz));
  irqtb_core_model core (.clk(clk), .rst(rst), .irq_call(irq_call),
    .return_from_irq_req(return_from_irq_req), .hold_full(hold_full), .phase_pulse(ph),
    .stack_full(sfull), .return_from_irq_pulse(return_from_irq));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    // Oscillators at the instruction rate keep halted time base runs short
    if (cyc % 2 == 0)
    begin
      osc_w <= ~osc_w;
      osc_r <= osc_w;
    end
  end
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("register", e, rd)
  endtask
  task automatic pulse(input logic [2:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 3'h0;
    @(posedge clk);
  endtask
  task automatic return_from_irq_go();
    return_from_irq_req <= 1'b1;
    @(posedge clk);
    return_from_irq_req <= 1'b0;
  endtask
  task automatic wait_call(input logic [7:0] v);
    logic php;
    php = ph;
    repeat (40)
    begin
      @(posedge clk);
      if (irq_call === 1'b1)
        break;
      php = ph;
    end
    `CHK("call", 1'b1, irq_call)
    `CHK("vector", v, vec)
    `CHK("phase", 1'b1, php)
  endtask
  task automatic quiet(input int n);
    repeat (n)
    begin
      @(posedge clk);
      `CHK("no call", 1'b0, irq_call)
    end
  endtask
  task automatic tick_wait(output int t);
    t = cyc;
    rd = 32'h0;
    while (rd[irqtb_pkg::TICK_PEND_BIT] !== 1'b1)
      apb(1'b0, PRI, 32'h0);
    t = cyc - t;
  endtask
  task automatic clk_period(input bit b, input int e);
    int k, t[2];
    logic p, s;
    k = 0;
    p = 1'b1;
    t = '{0, 0};
    repeat (300)
    begin
      @(posedge clk);
      s = b ? buz : lcd;
      if (s === 1'b1 && p === 1'b0 && k < 2)
      begin
        t[k] = cyc;
        k++;
      end
      p = s;
    end
    `CHK("clock period", e, t[1] - t[0])
  endtask
  task automatic halt_rtc(input logic e);
    logic seen;
    seen = 1'b0;
    halted <= 1'b1;
    // Arming needs a cycle after halt entry before events count
    repeat (3) @(posedge clk);
    ev <= 3'h4;
    repeat (8)
    begin
      @(posedge clk);
      ev <= 3'h0;
      if (wake === 1'b1)
        seen = 1'b1;
    end
    halted <= 1'b0;
    @(posedge clk);
    `CHK("wake", e, seen)
  endtask
  task automatic t_reset();
    rd_chk(PRI, 32'h0);
    rd_chk(TMR, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    `CHK("refused", 1'b1, perr)
  endtask
  task automatic t_regs();
    apb(1'b1, PRI, 32'h8E);
    rd_chk(PRI, 32'h0E);
    apb(1'b1, PRI, 32'hF0);
    rd_chk(PRI, 32'h70);
    apb(1'b1, TMR, 32'hFF);
    rd_chk(TMR, 32'h11);
    apb(1'b1, TMR, 32'h00);
    rd_chk(TMR, 32'h00);
    apb(1'b1, PRI, 32'h00);
  endtask
  task automatic t_counter();
    pulse(3'h1);
    rd_chk(TMR, 32'h10);
    apb(1'b1, TMR, 32'h11);
    apb(1'b1, PRI, 32'h01);
    wait_call(irqtb_pkg::VEC_CNT);
    rd_chk(TMR, 32'h01);
    rd_chk(PRI, 32'h00);
    return_from_irq_go();
    repeat (2) @(posedge clk);
    rd_chk(PRI, 32'h01);
    pulse(3'h2);
    wait_call(irqtb_pkg::VEC_CNT);
  endtask
  task automatic t_prio();
    apb(1'b1, PRI, 32'h0E);
    ext_n <= 1'b0;
    pulse(3'h6);
    quiet(12);
    rd_chk(PRI, 32'h5E);
    rd_chk(TMR, 32'h11);
    apb(1'b1, PRI, 32'h5F);
    wait_call(irqtb_pkg::VEC_EXT);
    quiet(12);
    return_from_irq_go();
    wait_call(irqtb_pkg::VEC_RTC);
    return_from_irq_go();
    wait_call(irqtb_pkg::VEC_CNT);
    rd_chk(PRI, 32'h0E);
    ext_n <= 1'b1;
  endtask
  task automatic t_stack();
    hold_full <= 1'b1;
    apb(1'b1, PRI, 32'h0F);
    pulse(3'h4);
    quiet(12);
    rd_chk(PRI, 32'h4F);
    hold_full <= 1'b0;
    wait_call(irqtb_pkg::VEC_RTC);
  endtask
  task automatic t_tick();
    int t;
    apb(1'b1, PRI, 32'h04);
    tick_wait(t);
    apb(1'b1, PRI, 32'h04);
    tick_wait(t);
    `CHK("tick period", 1'b1, t > TICK - 12 && t < TICK + 12)
    apb(1'b1, PRI, 32'h25);
    wait_call(irqtb_pkg::VEC_TICK);
  endtask
  task automatic t_halt();
    apb(1'b1, PRI, 32'h00);
    halt_rtc(1'b1);
    rd_chk(PRI, 32'h40);
    halt_rtc(1'b0);
  endtask
  task automatic halt_tick(input logic e);
    logic seen;
    seen = 1'b0;
    halted <= 1'b1;
    repeat (TICK + 64)
    begin
      @(posedge clk);
      if (wake === 1'b1)
        seen = 1'b1;
    end
    halted <= 1'b0;
    @(posedge clk);
    `CHK("tick wake", e, seen)
  endtask
  task automatic t_osc();
    fs_sel <= irqtb_pkg::CS_WDT;
    halted <= 1'b1;
    repeat (8) @(posedge clk);
    clk_period(1'b0, OUTP);
    halt_tick(1'b1);
    // The wake left the tick flag pending, so this halt must sleep on
    halt_tick(1'b0);
    fs_sel <= irqtb_pkg::CS_SYS;
  endtask
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
  initial
  begin
    {rst, psel, penable, pwrite, ext_n, halted} = 6'h22;
    {osc_w, osc_r, return_from_irq_req, hold_full} = 4'h0;
    {fs_sel, buz_sel} = 5'h00;
    {ev, paddr, pwdata, cyc, miscompares, total_checks} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_regs();
    t_counter();
    t_prio();
    t_stack();
    clk_period(1'b0, OUTP);
    clk_period(1'b1, OUTP);
    buz_sel <= 3'h1;
    repeat (4) @(posedge clk);
    clk_period(1'b1, 2 * OUTP);
    t_tick();
    t_halt();
    t_osc();
    print_verdict();
  end
endmodule
`default_nettype wire
